// ### nmpes_host.sv
// host controller for a two-plane NAND: erase, status poll, row setup, raw cycles
// assumes APB from software, flash pins asynchronous to ref_clk, rb high = ready
//
// Summary of operation
// - copy-back destination row must sit in the source row's plane.
// - after 11h only 70h, F1h, F2h, FFh until 81h.
// - intelligent copy-back: only status or reset between 11h and 8Ch.
// - two-plane cache: second row equals first with plane bit flipped.
// - erase is 60h plus three row cycles; page bits are ignored.
// - only D0h confirm starts the erase.
// - two-plane erase: two setups, one block per plane, one D0h.
// - status mode persists; 00h resumes array reading.
// - unused status bits are masked before evaluation.
`timescale 1ns/10ps
module nmpes_host import nmpes_pkg::*; #(
  parameter int PROGRAM_TIME_CYCLES = PROGRAM_TIME_CYC,
  parameter int PLANE_BIT           = PLANE_BIT_DEF,
  parameter int TMR_W               = 20
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             read_strobe_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        rb
);

  if (PROGRAM_TIME_CYCLES < 1 || PROGRAM_TIME_CYCLES >= (1 << TMR_W))
    $error("PROGRAM_TIME_CYCLES does not fit the timer");
  if (PLANE_BIT < 0 || PLANE_BIT >= ROW_W)
    $error("PLANE_BIT outside the row address");

  // ------------------------------------------------------------
  // step table
  // ------------------------------------------------------------
  function automatic nmpes_step_s step_of(input nmpes_ctrl_s c, input logic [3:0] i,
                                          input logic [23:0] a0, input logic [23:0] a1,
                                          input logic [7:0] d);
    nmpes_step_s s;
    logic [7:0]  stc;
    s   = '{K_DONE, 8'h00};
    stc = (c.stsel == 2'b01) ? FC_STAT_C1 : (c.stsel == 2'b10) ? FC_STAT_C2 : FC_STATUS;
    unique case (c.op)
      OP_CMD:    if (i == 4'h0) s = '{K_CMD, d};
      OP_ADDR:   if (i == 4'h0) s = '{K_ADDR, d};
      OP_WDATA:  if (i == 4'h0) s = '{K_WR, d};
      OP_RDATA:  if (i == 4'h0) s = '{K_RD, 8'h00};
      OP_WAITRB: if (i == 4'h0) s = '{K_WAIT, 8'h00};
      OP_STATUS: begin
        if (i == 4'h0) s = '{K_CMD, stc};
        if (i == 4'h1) s = '{K_RDST, 8'h00};
        if (i == 4'h2 && c.resume_read) s = '{K_CMD, FC_READ};
      end
      OP_ERASE: begin
        unique case (i)
          4'h0, 4'h4: s = '{K_CMD, FC_ERASE};
          4'h1: s = '{K_ADDR, a0[7:0]};
          4'h2: s = '{K_ADDR, a0[15:8]};
          4'h3: s = '{K_ADDR, a0[23:16]};
          4'h5: s = '{K_ADDR, a1[7:0]};
          4'h6: s = '{K_ADDR, a1[15:8]};
          4'h7: s = '{K_ADDR, a1[23:16]};
          4'h8: s = '{K_CMD, FC_CONFIRM};
          4'h9: s = '{K_WAIT, 8'h00};
          4'hA: s = '{K_CMD, FC_STATUS};
          4'hB: s = '{K_RDST, 8'h00};
          default: s = '{K_DONE, 8'h00};
        endcase
      end
      OP_ROWADR: begin
        unique case (i)
          4'h0: s = '{K_CMD, c.sel_plane2 ? FC_PLANE2 : FC_COPYBACK};
          4'h1, 4'h2: s = '{K_ADDR, 8'h00};
          4'h3: s = '{K_ADDR, a1[7:0]};
          4'h4: s = '{K_ADDR, a1[15:8]};
          4'h5: s = '{K_ADDR, a1[23:16]};
          default: s = '{K_DONE, 8'h00};
        endcase
      end
    endcase
    return s;
  endfunction

  function automatic logic cmd_after_dummy_ok(input logic [7:0] b);
    return b == FC_STATUS || b == FC_STAT_C1 || b == FC_STAT_C2 || b == FC_RESET ||
           b == FC_PLANE2 || b == FC_ICB;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FETCH   = 3'b001,
    ST_SETUP   = 3'b010,
    ST_WE_LOW  = 3'b011,
    ST_WE_HIGH = 3'b100,
    ST_RD_LOW  = 3'b101,
    ST_WAIT_RB = 3'b110,
    ST_END     = 3'b111
  } nmpes_state_e;

  nmpes_state_e       state;
  nmpes_ctrl_s        ctrl;
  logic [23:0]        addr0;
  logic [23:0]        addr1;
  logic [7:0]         data;
  logic [7:0]         stbyte;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [7:0]         poll_mask;
  logic [7:0]         res_mask;
  logic [3:0]         idx;
  logic [TMR_W-1:0]   tmr;
  logic               after_dummy;
  logic               cur_valid;
  logic               prev_valid;
  logic               cur_fail;
  logic               prev_fail;
  logic               last_cmd;
  logic [7:0]         io_s1, io_s2, io_s3;
  logic               rb_s1, rb_s2, rb_s3;
  logic               rb_level;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {io_s1, io_s2, io_s3} <= '0;
      {rb_s1, rb_s2, rb_s3} <= 3'b000;
      rb_level              <= 1'b0;
    end else begin
      {io_s1, io_s2, io_s3} <= {io_in, io_s1, io_s2};
      {rb_s1, rb_s2, rb_s3} <= {rb, rb_s1, rb_s2};
      if (rb_s2 == rb_s3) rb_level <= rb_s3;
    end
  end

  wire io_stable = (io_s2 == io_s3);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire access   = psel & penable & pready;
  wire wr       = access & pwrite;
  wire mapped   = paddr inside {OFF_CTRL, OFF_ADDR0, OFF_ADDR1, OFF_DATA, OFF_STAT,
                                OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_POLL_MASK, OFF_RES_MASK};
  wire start    = wr & (paddr == OFF_CTRL) & pwdata[CTRL_START];
  wire idle     = (state == ST_IDLE);
  wire [31:0] stat_word = {16'h0000, stbyte, 1'b0, prev_fail, cur_fail, prev_valid,
                           cur_valid, after_dummy, rb_level, ~idle};
  wire [31:0] rd_mux =
      (paddr == OFF_CTRL)      ? {22'h000000, ctrl.stsel, 1'b0, ctrl[6:0]} :
      (paddr == OFF_ADDR0)     ? {8'h00, addr0} :
      (paddr == OFF_ADDR1)     ? {8'h00, addr1} :
      (paddr == OFF_DATA)      ? {24'h000000, data} :
      (paddr == OFF_STAT)      ? stat_word :
      (paddr == OFF_IRQ_STAT)  ? {28'h0000000, irq_stat} :
      (paddr == OFF_IRQ_MASK)  ? {28'h0000000, irq_mask} :
      (paddr == OFF_POLL_MASK) ? {24'h000000, poll_mask} :
      (paddr == OFF_RES_MASK)  ? {24'h000000, res_mask} : 32'h00000000;

  // ------------------------------------------------------------
  // start checks
  // ------------------------------------------------------------
  nmpes_ctrl_s new_ctrl;
  assign new_ctrl = nmpes_ctrl_s'({pwdata[9:8], pwdata[6:0]});
  wire [23:0] wa0 = addr0;
  wire [23:0] wa1 = addr1;
  wire same_plane = (wa0[PLANE_BIT] == wa1[PLANE_BIT]);
  wire [23:0] plane_flip = wa0 ^ (24'h000001 << PLANE_BIT);
  logic refuse;
  always_comb begin
    refuse = ~idle;
    unique case (new_ctrl.op)
      OP_CMD:    refuse = refuse | (after_dummy & ~cmd_after_dummy_ok(data));
      OP_ADDR, OP_WDATA, OP_RDATA: refuse = refuse | after_dummy;
      OP_ERASE:  refuse = refuse | after_dummy | (new_ctrl.two_plane & same_plane);
      OP_ROWADR: refuse = refuse | (new_ctrl.sel_plane2 ? (wa1 != plane_flip)
                                                        : (~same_plane | after_dummy));
      default:   refuse = refuse;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  nmpes_step_s step;
  assign step = step_of(ctrl, idx, addr0, addr1, data);
  wire [7:0] st_live   = io_s3;
  wire poll_ready      = ((st_live & poll_mask) == poll_mask);
  wire tmr_out         = (tmr >= TMR_W'(PROGRAM_TIME_CYCLES));
  wire [3:0] idx_inc   = (ctrl.op == OP_ERASE && !ctrl.two_plane && idx == 4'h3) ?
                         4'h8 : idx + 4'h1;
  wire [7:0] st_masked = st_live & res_mask;
  wire cur_ok          = ctrl.cache_status ? st_live[SB_TRUE_RDY]
                                           : st_live[SB_CACHE_RDY];
  wire prev_ok         = ctrl.cache_status & st_live[SB_CACHE_RDY];

  logic [IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[IRQ_REFUSED] = start & refuse;
    ev[IRQ_DONE]    = (state == ST_END);
    ev[IRQ_TIMEOUT] = (state == ST_WAIT_RB || state == ST_RD_LOW) & tmr_out;
    ev[IRQ_FAIL]    = (state == ST_RD_LOW) & (step.kind == K_RDST) & io_stable &
                      (tmr >= TMR_W'(RD_SETTLE)) & poll_ready &
                      ((st_masked[SB_CUR_FAIL] & cur_ok) |
                       (st_masked[SB_PREV_FAIL] & prev_ok));
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      ctrl  <= '{2'b00, 1'b0, 1'b0, 1'b0, 1'b0, OP_CMD};
      idx   <= 4'h0;
      tmr   <= '0;
      ce_n  <= 1'b1;
      cle   <= 1'b0;
      ale   <= 1'b0;
      we_n  <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe  <= 1'b0;
      stbyte <= 8'h00;
      after_dummy <= 1'b0;
      last_cmd    <= 1'b0;
      {cur_valid, prev_valid, cur_fail, prev_fail} <= 4'b0000;
    end else begin
      unique case (state)
        ST_IDLE: if (start && !refuse) begin
          ctrl  <= new_ctrl;
          idx   <= 4'h0;
          ce_n  <= 1'b0;
          state <= ST_FETCH;
        end
        ST_FETCH: begin
          tmr <= '0;
          unique case (step.kind)
            K_CMD, K_ADDR, K_WR: begin
              cle    <= (step.kind == K_CMD);
              ale    <= (step.kind == K_ADDR);
              io_out <= step.val;
              io_oe  <= 1'b1;
              last_cmd <= (step.kind == K_CMD);
              state  <= ST_SETUP;
            end
            K_RD, K_RDST: begin
              read_strobe_n <= 1'b0;
              state <= ST_RD_LOW;
            end
            K_WAIT: state <= ST_WAIT_RB;
            default: state <= ST_END;
          endcase
        end
        ST_SETUP:  begin
          we_n  <= 1'b0;
          state <= ST_WE_LOW;
        end
        ST_WE_LOW: begin
          we_n  <= 1'b1;
          state <= ST_WE_HIGH;
        end
        ST_WE_HIGH: begin
          if (last_cmd && io_out == FC_DUMMY) after_dummy <= 1'b1;
          if (last_cmd && (io_out == FC_PLANE2 || io_out == FC_ICB || io_out == FC_RESET))
            after_dummy <= 1'b0;
          cle   <= 1'b0;
          ale   <= 1'b0;
          io_oe <= 1'b0;
          idx   <= idx_inc;
          state <= ST_FETCH;
        end
        ST_RD_LOW: begin
          tmr <= tmr + TMR_W'(1);
          if (tmr >= TMR_W'(RD_SETTLE) && io_stable) begin
            // strobe stays low while polling; the device keeps the byte live
            if (step.kind == K_RD || poll_ready) begin
              read_strobe_n <= 1'b1;
              idx   <= idx_inc;
              state <= ST_FETCH;
            end
            if (step.kind == K_RDST) begin
              stbyte     <= st_live;
              cur_valid  <= cur_ok;
              prev_valid <= prev_ok;
              cur_fail   <= st_masked[SB_CUR_FAIL] & cur_ok;
              prev_fail  <= st_masked[SB_PREV_FAIL] & prev_ok;
            end
          end
          if (tmr_out) begin
            read_strobe_n <= 1'b1;
            state <= ST_END;
          end
        end
        ST_WAIT_RB: begin
          tmr <= tmr + TMR_W'(1);
          // give the busy edge time to cross the synchroniser first
          if (tmr >= TMR_W'(WB_SETTLE) && rb_level) begin
            idx   <= idx_inc;
            state <= ST_FETCH;
          end else if (tmr_out) begin
            state <= ST_END;
          end
        end
        ST_END: begin
          ce_n  <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers and bus answer
  // ------------------------------------------------------------
  wire [IRQ_W-1:0] irq_clr = (wr && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | ev;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr0     <= '0;
      addr1     <= '0;
      data      <= 8'h00;
      irq_stat  <= '0;
      irq_mask  <= '0;
      poll_mask <= POLL_MASK_RST;
      res_mask  <= RES_MASK_RST;
      irq       <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
      pready   <= psel & penable & ~pready;
      pslverr  <= psel & penable & ~pready & ~mapped;
      prdata   <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
      if (wr && idle) begin
        if (paddr == OFF_ADDR0) addr0 <= pwdata[23:0];
        if (paddr == OFF_ADDR1) addr1 <= pwdata[23:0];
        if (paddr == OFF_DATA)  data  <= pwdata[7:0];
      end
      if (wr && paddr == OFF_IRQ_MASK)  irq_mask  <= pwdata[IRQ_W-1:0];
      if (wr && paddr == OFF_POLL_MASK) poll_mask <= pwdata[7:0];
      if (wr && paddr == OFF_RES_MASK)  res_mask  <= pwdata[7:0];
      if (state == ST_RD_LOW && step.kind == K_RD && tmr >= TMR_W'(RD_SETTLE) && io_stable)
        data <= io_s3;
    end
  end

endmodule

// ### nmpes_pkg.sv
// package for the two-plane NAND program/erase/status host controller
// assumes a 32-bit APB register bus and an 8-bit asynchronous NAND port
package nmpes_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_ADDR0     = 8'h04;
  localparam logic [7:0] OFF_ADDR1     = 8'h08;
  localparam logic [7:0] OFF_DATA      = 8'h0C;
  localparam logic [7:0] OFF_STAT      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OFF_POLL_MASK = 8'h1C;
  localparam logic [7:0] OFF_RES_MASK  = 8'h20;

  localparam logic [7:0] POLL_MASK_RST = 8'h40;
  localparam logic [7:0] RES_MASK_RST  = 8'h03;
  localparam int         CTRL_START    = 31;

  // ------------------------------------------------------------
  // flash command bytes
  // ------------------------------------------------------------
  localparam logic [7:0] FC_READ     = 8'h00;
  localparam logic [7:0] FC_PROG     = 8'h10;
  localparam logic [7:0] FC_DUMMY    = 8'h11;
  localparam logic [7:0] FC_ERASE    = 8'h60;
  localparam logic [7:0] FC_STATUS   = 8'h70;
  localparam logic [7:0] FC_STAT_C1  = 8'hF1;
  localparam logic [7:0] FC_STAT_C2  = 8'hF2;
  localparam logic [7:0] FC_PLANE2   = 8'h81;
  localparam logic [7:0] FC_COPYBACK = 8'h85;
  localparam logic [7:0] FC_ICB      = 8'h8C;
  localparam logic [7:0] FC_CONFIRM  = 8'hD0;
  localparam logic [7:0] FC_RESET    = 8'hFF;

  // status byte bit positions; fail = 1, ready = 1
  localparam int SB_CUR_FAIL  = 0;
  localparam int SB_PREV_FAIL = 1;
  localparam int SB_TRUE_RDY  = 5;
  localparam int SB_CACHE_RDY = 6;
  localparam int SB_NOT_WP    = 7;

  // irq bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_FAIL    = 3;
  localparam int IRQ_W       = 4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ         = 10;
  localparam int PROGRAM_TIME_US = 10000;
  localparam int PROGRAM_TIME_CYC = PROGRAM_TIME_US * CLK_MHZ;
  localparam int RD_SETTLE       = 4;
  localparam int WB_SETTLE       = 4;
  localparam int ROW_W           = 24;
  localparam int PLANE_BIT_DEF   = 7;

  typedef enum logic [2:0] {
    OP_CMD    = 3'b000,
    OP_ADDR   = 3'b001,
    OP_WDATA  = 3'b010,
    OP_RDATA  = 3'b011,
    OP_WAITRB = 3'b100,
    OP_STATUS = 3'b101,
    OP_ERASE  = 3'b110,
    OP_ROWADR = 3'b111
  } nmpes_op_e;

  typedef enum logic [2:0] {
    K_CMD  = 3'b000,
    K_ADDR = 3'b001,
    K_WR   = 3'b010,
    K_RD   = 3'b011,
    K_RDST = 3'b100,
    K_WAIT = 3'b101,
    K_DONE = 3'b110
  } nmpes_kind_e;

  typedef struct packed {
    nmpes_kind_e kind;
    logic [7:0]  val;
  } nmpes_step_s;

  typedef struct packed {
    logic [1:0] stsel;
    logic       cache_status;
    logic       resume_read;
    logic       sel_plane2;
    logic       two_plane;
    nmpes_op_e  op;
  } nmpes_ctrl_s;

endpackage

// ### nmpes_host_checker.sv
// pin and bus assertions for the two-plane NAND host controller
// assumes one ref_clk domain, reset async active high
`timescale 1ns/10ps
module nmpes_host_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ce_n,
  input wire logic        cle,
  input wire logic        ale,
  input wire logic        we_n,
  input wire logic        read_strobe_n,
  input wire logic [7:0]  io_out,
  input wire logic        io_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_apb_answer: assert property (psel && $rose(penable) |=> pready && psel && penable)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready && prdata == 32'h0)
    else $error("pready or prdata held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_strobe_width: assert property ($fell(we_n) |=> we_n)
    else $error("write strobe wider than one cycle");
  a_byte_hold: assert property ($rose(we_n) |-> $stable(io_out) && $stable(cle) && io_oe)
    else $error("byte changed at strobe rise");
  a_strobe_gap: assert property ($rose(we_n) |-> we_n [*2])
    else $error("strobes too close");
  a_latch_qual: assert property (!we_n |-> !ce_n && io_oe && read_strobe_n && !(cle && ale))
    else $error("strobe without proper qualifiers");
  a_read_qual: assert property (!read_strobe_n |-> !ce_n && !io_oe && we_n && !cle)
    else $error("read strobe while driving");
endmodule

// ### nmpes_flash_model.sv
// behavioural two-plane NAND: command latch, erase busy, status byte
// assumes ref_clk paces busy time and latches the byte driven; pins are sampled on their own edges
`timescale 1ns/10ps
module nmpes_flash_model import nmpes_pkg::*; (
  input wire logic       ref_clk,
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic       erase_fail,
  output logic [7:0]     io_in,
  output logic           rb
);
  logic [7:0] last_cmd  = 8'hFF;
  logic [7:0] last_io   = 8'h00;
  logic       stat_mode = 1'b0;
  logic       pend      = 1'b0;
  logic       efail     = 1'b0;
  int         cyc       = 0;
  int         busy_end  = 0;
  int         n_setup   = 0;
  int         n_erase   = 0;
  int         n_addr    = 0;
  int         n_fall    = 0;
  wire        ready     = (cyc >= busy_end);
  wire        drive     = !ce_n && !read_strobe_n;
  wire  [7:0] status    = {1'b1, ready, ready, 4'h0, efail};
  assign rb = ready;
  // released bus shows the inverse of the last byte driven, never a stale copy
  assign io_in = drive ? (stat_mode ? status : 8'h5A) : ~last_io;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (drive) last_io <= io_in;
  end
  always @(posedge we_n) begin
    if (ce_n === 1'b0 && cle === 1'b1) begin
      last_cmd = io_out;
      stat_mode = io_out inside {FC_STATUS, FC_STAT_C1, FC_STAT_C2};
      if (io_out == FC_RESET) begin
        busy_end = cyc + 150;
        efail = 1'b0;
      end
      if (io_out == FC_ERASE) begin
        pend = 1'b1;
        n_setup++;
      end
      // page bits never used: only block-level erase counted
      if (io_out == FC_CONFIRM && pend) begin
        pend = 1'b0;
        n_erase++;
        efail = erase_fail;
        busy_end = cyc + 40;
      end
    end else if (ce_n === 1'b0 && ale === 1'b1) begin
      n_addr++;
    end
  end
  always @(negedge read_strobe_n) n_fall++;
endmodule

// ### test_nmpes_host.sv
// self-checking bench: APB tasks drive the host, flash model answers the pins
// assumes the checker below is bound to the host controller
`timescale 1ns/10ps
module test_nmpes_host import nmpes_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        erase_fail = 1'b0;
  logic        err;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, ce_n, cle, ale, we_n, read_strobe_n, io_oe, rb;
  logic [7:0]  io_out, io_in;
  int          miscompares = 0;
  int          checks_done = 0;
  int          e, s, a, f;
  always #50 ref_clk = ~ref_clk;
  // short program time keeps the status-poll timeout test brief
  nmpes_host #(.PROGRAM_TIME_CYCLES(400)) uut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .rb(rb));
  nmpes_flash_model flash (.ref_clk(ref_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .io_out(io_out), .erase_fail(erase_fail), .io_in(io_in),
    .rb(rb));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    apb(1'b0, ad, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, ad, d, q);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] ctl(input nmpes_op_e op, input logic [31:0] fl);
    return (32'h1 << CTRL_START) | fl | 32'(op);
  endfunction
  // start an operation, then poll busy until it clears
  task automatic run(input logic [31:0] c);
    logic [31:0] q;
    wr(OFF_CTRL, c);
    do rd(OFF_STAT, q); while (q[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] b);
    wr(OFF_DATA, 32'(b));
    run(ctl(OP_CMD, 32'h0));
  endtask
  task automatic irqs(output logic [31:0] q);
    rd(OFF_IRQ_STAT, q);
    wr(OFF_IRQ_STAT, 32'hF);
  endtask
  task automatic snap();
    e = flash.n_erase;
    s = flash.n_setup;
    a = flash.n_addr;
    f = flash.n_fall;
  endtask
  task automatic summarize();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] q;
    logic [7:0]  codes [3];
    codes = '{FC_STATUS, FC_STAT_C1, FC_STAT_C2};
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFF_IRQ_MASK, q);
    chk(q, 32'h0, "irq_mask");
    rd(OFF_POLL_MASK, q);
    chk(q, 32'(POLL_MASK_RST), "poll_mask");
    rd(OFF_RES_MASK, q);
    chk(q, 32'(RES_MASK_RST), "res_mask");
    rd(8'h24, q);
    chk({q[30:0], err}, 32'h1, "unmapped");
    wr(OFF_ADDR0, 32'h000123);
    snap();
    run(ctl(OP_ERASE, 32'h0));
    chk(32'(flash.n_erase - e), 32'h1, "erase count");
    chk(32'(flash.n_addr - a), 32'h3, "erase addr");
    rd(OFF_STAT, q);
    chk(32'(q[15:8]), 32'hE0, "status byte");
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h1, "irq done");
    wr(OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0, "irq cleared");
    erase_fail <= 1'b1;
    wr(OFF_ADDR0, 32'h000100);
    wr(OFF_ADDR1, 32'h000180);
    snap();
    run(ctl(OP_ERASE, 32'h8));
    chk(32'(flash.n_setup - s), 32'h2, "setups");
    chk(32'(flash.n_erase - e), 32'h1, "confirms");
    chk(32'(flash.n_addr - a), 32'h6, "plane addr");
    rd(OFF_STAT, q);
    chk(32'(q[15:8]), 32'hE1, "fail byte");
    irqs(q);
    chk(32'(q[3]), 32'h1, "fail irq");
    erase_fail <= 1'b0;
    wr(OFF_ADDR1, 32'h000100);
    wr(OFF_IRQ_MASK, 32'h2);
    snap();
    run(ctl(OP_ERASE, 32'h8));
    chk(32'(flash.n_setup - s), 32'h0, "same plane");
    chk(32'(irq), 32'h1, "irq refused");
    irqs(q);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0, "irq off");
    chk(32'(q[1]), 32'h1, "refused bit");
    cmd(FC_DUMMY);
    rd(OFF_STAT, q);
    chk(32'(q[2]), 32'h1, "guard set");
    cmd(FC_PROG);
    irqs(q);
    chk(32'(q[1]), 32'h1, "cmd refused");
    chk(32'(flash.last_cmd), 32'(FC_DUMMY), "last cmd");
    run(ctl(OP_ROWADR, 32'h10));
    irqs(q);
    chk(32'(q[1]), 32'h1, "row unflipped");
    run(ctl(OP_ROWADR, 32'h0));
    irqs(q);
    chk(32'(q[1]), 32'h1, "85h guarded");
    wr(OFF_ADDR1, 32'h000180);
    snap();
    run(ctl(OP_ROWADR, 32'h10));
    chk(32'(flash.n_addr - a), 32'h5, "row addr");
    rd(OFF_STAT, q);
    chk(32'(q[2]), 32'h0, "guard clear");
    run(ctl(OP_ROWADR, 32'h0));
    irqs(q);
    chk(32'(q[1]), 32'h1, "plane differs");
    cmd(FC_RESET);
    snap();
    run(ctl(OP_STATUS, 32'h0));
    chk(32'(flash.n_fall - f), 32'h1, "one strobe");
    rd(OFF_STAT, q);
    chk(32'(q[15:8]), 32'hE0, "live status");
    chk(32'(q[4:3]), 32'h1, "plain valid");
    for (int i = 0; i < 3; i++) begin
      run(ctl(OP_STATUS, 32'(i) << 8));
      chk(32'(flash.last_cmd), 32'(codes[i]), "status cmd");
    end
    run(ctl(OP_STATUS, 32'h40));
    rd(OFF_STAT, q);
    chk(32'(q[4:3]), 32'h3, "cache valid");
    run(ctl(OP_STATUS, 32'h20));
    chk(32'(flash.last_cmd), 32'(FC_READ), "resume");
    run(ctl(OP_RDATA, 32'h0));
    rd(OFF_DATA, q);
    chk(q, 32'h5A, "read byte");
    snap();
    run(ctl(OP_ADDR, 32'h0));
    run(ctl(OP_WDATA, 32'h0));
    run(ctl(OP_WAITRB, 32'h0));
    chk(32'(flash.n_addr - a), 32'h1, "addr op");
    wr(OFF_POLL_MASK, 32'h10);
    run(ctl(OP_STATUS, 32'h0));
    irqs(q);
    chk(32'(q[2]), 32'h1, "timeout");
    wr(OFF_POLL_MASK, 32'(POLL_MASK_RST));
    summarize();
  end
endmodule
bind nmpes_host nmpes_host_checker u_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
  .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
  .io_oe(io_oe));
